// >>> src/jlink_defines.svh
// Constants for the transmit link configuration and alarm block
`ifndef JLINK_DEFINES_SVH
`define JLINK_DEFINES_SVH
`define LANES_MAX 8
`define REG_CTRL 4'h0
`define REG_MODE 4'h1
`define REG_ALARM 4'h2
`define REG_MASK 4'h3
`define REG_PARAM0 4'h4
`define REG_PARAM1 4'h5
`define REG_PARAM2 4'h6
`define CTRL_EN_BIT 0
`define CTRL_PDA_BIT 1
`define CTRL_PDB_BIT 2
`define CTRL_SCR_BIT 3
`define CTRL_SEL_BIT 4
`define ALM_CLK_BIT 8
`define MASK_RESET 9'h1ff
`define JESDV_VAL 3'h1
`define SUBCLASS_VAL 3'h1
`define E_VAL 8'h01
`define UNMAPPED_READ 32'hdeadbeef
`endif

// >>> src/jlink_pkg.sv
// Types used by the converter end of the link configuration block
package jlink_pkg;
   typedef enum logic [1:0] {enc_8b10b, enc_64b66b} enc_e;
   typedef struct packed {
      logic [7:0] f;
      logic [4:0] l;
      logic [4:0] m;
      logic [4:0] n;
      logic [4:0] np;
      logic [4:0] s;
      logic [7:0] r_x8;
      logic hd;
      logic enc;
      logic valid;
   } mode_s;
endpackage : jlink_pkg

// >>> src/jlink_if.sv
// Connection between the converter end and the receiver end
`timescale 1ns/1ps
`default_nettype none
interface jlink_if;
   logic link_enable;
   logic power_down_channel_a;
   logic power_down_channel_b;
   logic [4:0] link_mode_select;
   logic [7:0] frames_per_multiframe_field;
   logic [7:0] device_id;
   logic scrambler_enable;
   logic status_sel_alarm;
   logic clear_clock_alarm;
   logic [7:0] clear_lane_alarm;
   logic clock_upset_alarm;
   logic [7:0] lane_fifo_alarm;
   logic calibration_status_pin;
   logic serializer_power_down;
   logic [7:0] ilas_checksum;
   logic [7:0] ilas_f;
   logic [4:0] ilas_l;
   logic [4:0] ilas_m;
   logic [7:0] ilas_r_x8;
   logic ilas_active;
   modport device (input link_enable, power_down_channel_a, power_down_channel_b, link_mode_select,
      frames_per_multiframe_field, device_id, scrambler_enable, status_sel_alarm, clear_clock_alarm,
      clear_lane_alarm, output clock_upset_alarm, lane_fifo_alarm, calibration_status_pin,
      serializer_power_down, ilas_checksum, ilas_f, ilas_l, ilas_m, ilas_r_x8, ilas_active);
   modport host (output link_enable, power_down_channel_a, power_down_channel_b, link_mode_select,
      frames_per_multiframe_field, device_id, scrambler_enable, status_sel_alarm, clear_clock_alarm,
      clear_lane_alarm, input clock_upset_alarm, lane_fifo_alarm, calibration_status_pin,
      serializer_power_down, ilas_checksum, ilas_f, ilas_l, ilas_m, ilas_r_x8, ilas_active);
endinterface : jlink_if
`default_nettype wire

// >>> src/jlink_device.sv
// Converter end: mode decode, alignment parameters, clock and FIFO alarms
// Summary of operation
// (RQ1) Flag clock alarm on any A/B mismatch; code ignores a mismatch while either channel is powered down
// (RQ2) Clock alarm holds until written one
// (RQ3) Host recovers clock alarm in order
// (RQ4) Host clears spurious alarm after power-up
// (RQ5) Clock alarm on status bit and pin
// (RQ6) Set lane alarm on FIFO pointer upset; code sets it only while the link is enabled
// (RQ7) Enable low then high resets FIFOs
// (RQ8) Mode selector derives transport parameters
// (RQ9) Mode fixes bits per lane per sample
// (RQ10) K used in 8B/10B, ignored otherwise
// (RQ11) E is one in 64B/66B only
// (RQ12) Alignment parameters sent only in 8B/10B
// (RQ13) Fixed alignment fields always send zero
// (RQ14) Control bits per sample sent zero
// (RQ15) Revision and subclass fields send one
// (RQ16) Device id, scrambler user set; lane id derived
// (RQ17) Mode derives F, L, M, N, N', S
// (RQ18) Converter count may differ from channels
// (RQ19) Checksum is field sum modulo 256
// (RQ20) Host changes parameters only while disabled
// (RQ21) Disabled link held reset, serializers off
// (RQ22) Sticky alarm bits, masked summary indication
`timescale 1ns/1ps
`default_nettype none
`include "jlink_defines.svh"
module jlink_device #(
   parameter int LANES = `LANES_MAX
) (
   input wire logic sys_clk,
   input wire logic resetn,
   jlink_if.device link,
   input wire logic [1:0] chan_a_clk_phase,
   input wire logic [1:0] chan_b_clk_phase,
   input wire logic [LANES-1:0] fifo_pointer_upset,
   output logic [LANES-1:0] fifo_reset_n,
   output logic [LANES*5-1:0] lane_id
);
   jlink_pkg::mode_s mode_dec;
   jlink_pkg::mode_s mode_q;
   logic en_q;
   logic clk_mismatch;
   logic [LANES-1:0] upset_q1;
   logic [LANES-1:0] upset_q2;
   logic [7:0] sum;
   logic [7:0] k_q;
   logic [7:0] did_q;
   logic scr_q;

   // Unlisted modes decode invalid, so nothing is sent for them
   function automatic jlink_pkg::mode_s decode(input logic [4:0] sel);
      jlink_pkg::mode_s d;
      d = '0;
      d.valid = 1'b1;
      case (sel)  // RQ8 RQ17 RQ9
         5'h00: d = '{8'h08, 5'h08, 5'h08, 5'h0c, 5'h0c, 5'h05, 8'h40, 1'b0, 1'b0, 1'b1};
         5'h01: d = '{8'h02, 5'h06, 5'h04, 5'h0c, 5'h0c, 5'h02, 8'h50, 1'b1, 1'b0, 1'b1};
         5'h02: d = '{8'h01, 5'h04, 5'h04, 5'h08, 5'h08, 5'h01, 8'h50, 1'b0, 1'b0, 1'b1};
         5'h03: d = '{8'h05, 5'h04, 5'h04, 5'h0a, 5'h0a, 5'h04, 8'h64, 1'b0, 1'b0, 1'b1};
         5'h04: d = '{8'h02, 5'h03, 5'h04, 5'h0c, 5'h0c, 5'h01, 8'h84, 1'b1, 1'b1, 1'b1};
         5'h05: d = '{8'h02, 5'h02, 5'h04, 5'h08, 5'h08, 5'h01, 8'h84, 1'b0, 1'b1, 1'b1};
         5'h06: d = '{8'h02, 5'h06, 5'h04, 5'h0c, 5'h0c, 5'h02, 8'h42, 1'b1, 1'b1, 1'b1};
         5'h07: d = '{8'h01, 5'h04, 5'h04, 5'h08, 5'h08, 5'h01, 8'h42, 1'b0, 1'b1, 1'b1};
         5'h08: d = '{8'h03, 5'h04, 5'h04, 5'h0c, 5'h0c, 5'h02, 8'h63, 1'b0, 1'b1, 1'b1};
         5'h09: d = '{8'h01, 5'h08, 5'h04, 5'h08, 5'h08, 5'h02, 8'h28, 1'b0, 1'b0, 1'b1};
         5'h0a: d = '{8'h05, 5'h08, 5'h08, 5'h0a, 5'h0a, 5'h04, 8'h32, 1'b0, 1'b0, 1'b1};
         5'h0e: d = '{8'h03, 5'h08, 5'h08, 5'h0c, 5'h0c, 5'h02, 8'h31, 1'b0, 1'b1, 1'b1};
         default: d = '0;
      endcase
      return d;
   endfunction : decode

   // M may exceed physical channels; receiver reinterleaves streams RQ18
   always_comb begin
      mode_dec = decode(link.link_mode_select);
   end

   // Parameters latched only on enable rise, so mid-run writes cannot glitch the link
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         en_q <= 1'b0;
         mode_q <= '0;
         k_q <= 8'h00;
         did_q <= 8'h00;
         scr_q <= 1'b0;
      end else begin
         en_q <= link.link_enable;
         if (link.link_enable && !en_q) begin
            mode_q <= mode_dec; // RQ20
            k_q <= link.frames_per_multiframe_field; // RQ10
            did_q <= link.device_id; // RQ16
            scr_q <= link.scrambler_enable; // RQ16
         end
      end
   end

   // Checksum over all sent fields; fixed-zero fields add nothing RQ13 RQ14
   always_comb begin
      sum = 8'(mode_q.f - 8'h01) + 8'(mode_q.l - 5'h01) + 8'(mode_q.m - 5'h01) + 8'(mode_q.n - 5'h01)
         + 8'(mode_q.np - 5'h01) + 8'(mode_q.s - 5'h01) + k_q
         + did_q + 8'(scr_q) + 8'(`JESDV_VAL) + 8'(`SUBCLASS_VAL) // RQ15
         + 8'(mode_q.hd & 1'b0); // RQ19
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.ilas_active <= 1'b0;
         link.ilas_checksum <= 8'h00;
         link.ilas_f <= 8'h00;
         link.ilas_l <= 5'h00;
         link.ilas_m <= 5'h00;
         link.ilas_r_x8 <= 8'h00;
      end else begin
         // Drops with enable at once, not a cycle late
         link.ilas_active <= link.link_enable && en_q && mode_q.valid && !mode_q.enc; // RQ12 RQ10 RQ11
         link.ilas_checksum <= sum;
         link.ilas_f <= mode_q.f;
         link.ilas_l <= mode_q.l;
         link.ilas_m <= mode_q.m;
         link.ilas_r_x8 <= mode_q.r_x8; // RQ9
      end
   end

   // Serializers follow enable; no wait for a frame boundary
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.serializer_power_down <= 1'b1;
      end else begin
         link.serializer_power_down <= !link.link_enable; // RQ21
      end
   end

   // Lane ids fixed per lane index RQ16
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               lane_id[g*5 +: 5] <= 5'h00;
            end else begin
               lane_id[g*5 +: 5] <= 5'(g);
            end
         end
         // FIFOs sit in reset for as long as the link is off
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               fifo_reset_n[g] <= 1'b0;
            end else begin
               fifo_reset_n[g] <= link.link_enable; // RQ7 RQ21
            end
         end
      end
   endgenerate

   // Upset inputs come from the serializer domain
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         upset_q1 <= '0;
         upset_q2 <= '0;
      end else begin
         upset_q1 <= fifo_pointer_upset;
         upset_q2 <= upset_q1;
      end
   end

   // One powered-down channel would otherwise look like a permanent upset
   always_comb begin
      clk_mismatch = (chan_a_clk_phase != chan_b_clk_phase) && !link.power_down_channel_a
         && !link.power_down_channel_b; // RQ1
   end

   // Set beats clear on the same edge RQ2 RQ22
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.clock_upset_alarm <= 1'b0;
      end else if (clk_mismatch) begin
         link.clock_upset_alarm <= 1'b1; // RQ1
      end else if (link.clear_clock_alarm) begin
         link.clock_upset_alarm <= 1'b0; // RQ2 RQ4
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.lane_fifo_alarm <= 8'h00;
      end else begin
         // Only while enabled; a disabled FIFO sits in reset anyway
         for (int i = 0; i < 8; i++) begin
            if (i < LANES && upset_q2[i] && link.link_enable) begin
               link.lane_fifo_alarm[i] <= 1'b1; // RQ6
            end else if (link.clear_lane_alarm[i]) begin
               link.lane_fifo_alarm[i] <= 1'b0; // RQ22
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.calibration_status_pin <= 1'b0;
      end else begin
         // Registered copy, one cycle behind the status bit
         link.calibration_status_pin <= link.status_sel_alarm && link.clock_upset_alarm; // RQ5
      end
   end
endmodule : jlink_device
`default_nettype wire

// >>> src/jlink_host.sv
// Receiver end: Avalon-MM register slave driving the link controls
`timescale 1ns/1ps
`default_nettype none
`include "jlink_defines.svh"
module jlink_host (
   input wire logic sys_clk,
   input wire logic resetn,
   jlink_if.host link,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic alarm_summary
);
   logic [8:0] mask;
   logic [8:0] alarms;
   logic done;

   always_comb begin
      alarms = {link.clock_upset_alarm, link.lane_fifo_alarm};
   end

   // One wait cycle per access keeps readdata registered
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
      end else begin
         done <= (avs_read || avs_write) && !done;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !done);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link.link_enable <= 1'b0;
         link.power_down_channel_a <= 1'b0;
         link.power_down_channel_b <= 1'b0;
         link.scrambler_enable <= 1'b0;
         link.status_sel_alarm <= 1'b0;
         link.link_mode_select <= 5'h00;
         link.frames_per_multiframe_field <= 8'h00;
         link.device_id <= 8'h00;
         link.clear_clock_alarm <= 1'b0;
         link.clear_lane_alarm <= 8'h00;
         mask <= `MASK_RESET;
      end else begin
         link.clear_clock_alarm <= 1'b0;
         link.clear_lane_alarm <= 8'h00;
         // Write lands on the edge that ends the wait
         if (avs_write && done) begin
            if (avs_address == `REG_CTRL) begin
               link.link_enable <= avs_writedata[`CTRL_EN_BIT]; // RQ3 RQ7
               link.power_down_channel_a <= avs_writedata[`CTRL_PDA_BIT];
               link.power_down_channel_b <= avs_writedata[`CTRL_PDB_BIT];
               link.scrambler_enable <= avs_writedata[`CTRL_SCR_BIT];
               link.status_sel_alarm <= avs_writedata[`CTRL_SEL_BIT];
            end else if (avs_address == `REG_MODE && !link.link_enable) begin
               // Ignored while enabled RQ20
               link.link_mode_select <= avs_writedata[4:0];
               link.frames_per_multiframe_field <= avs_writedata[15:8];
               link.device_id <= avs_writedata[23:16];
            end else if (avs_address == `REG_ALARM) begin
               link.clear_clock_alarm <= avs_writedata[`ALM_CLK_BIT]; // RQ2 RQ4
               link.clear_lane_alarm <= avs_writedata[7:0]; // RQ22
            end else if (avs_address == `REG_MASK) begin
               mask <= avs_writedata[8:0];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !done) begin
         if (avs_address == `REG_CTRL) begin
            avs_readdata <= {27'h0, link.status_sel_alarm, link.scrambler_enable, link.power_down_channel_b,
               link.power_down_channel_a, link.link_enable};
         end else if (avs_address == `REG_MODE) begin
            avs_readdata <= {8'h0, link.device_id, link.frames_per_multiframe_field, 3'h0,
               link.link_mode_select};
         end else if (avs_address == `REG_ALARM) begin
            avs_readdata <= {23'h0, alarms};
         end else if (avs_address == `REG_MASK) begin
            avs_readdata <= {23'h0, mask};
         end else if (avs_address == `REG_PARAM0) begin
            avs_readdata <= {link.ilas_r_x8, link.ilas_checksum, 6'h0, link.serializer_power_down,
               link.ilas_active, link.calibration_status_pin, 7'h0};
         end else if (avs_address == `REG_PARAM1) begin
            avs_readdata <= {14'h0, link.ilas_m, link.ilas_l, link.ilas_f};
         end else begin
            avs_readdata <= `UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_summary <= 1'b0;
      end else begin
         alarm_summary <= |(alarms & ~mask); // RQ22
      end
   end
endmodule : jlink_host
`default_nettype wire

// >>> bench/jlink_monitor.sv
// Concurrent checks on the signals between the two link ends
`timescale 1ns/1ps
`default_nettype none
module jlink_monitor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic link_enable,
   input wire logic power_down_channel_a,
   input wire logic power_down_channel_b,
   input wire logic [4:0] link_mode_select,
   input wire logic status_sel_alarm,
   input wire logic clear_clock_alarm,
   input wire logic [7:0] clear_lane_alarm,
   input wire logic clock_upset_alarm,
   input wire logic [7:0] lane_fifo_alarm,
   input wire logic calibration_status_pin,
   input wire logic serializer_power_down,
   input wire logic [7:0] ilas_checksum,
   input wire logic [7:0] ilas_r_x8,
   input wire logic ilas_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_en_rise;
      !link_enable ##1 link_enable;
   endsequence
   sequence s_en_held;
      link_enable [*3];
   endsequence
   a_clk_alarm_hold: assert property (clock_upset_alarm && !clear_clock_alarm |=> clock_upset_alarm)
      else $error("clock alarm dropped");
   a_pd_gates_alarm: assert property (power_down_channel_a || power_down_channel_b |=> !$rose(clock_upset_alarm))
      else $error("clock alarm with channel off");
   a_pin_shows_alarm: assert property (status_sel_alarm |=> calibration_status_pin == $past(clock_upset_alarm))
      else $error("status pin wrong");
   a_serdes_off: assert property (1'b1 |=> serializer_power_down == !$past(link_enable))
      else $error("serializer power wrong");
   a_lane_alarm_hold: assert property (1'b1 |=> (($past(lane_fifo_alarm) & ~$past(clear_lane_alarm)) & ~lane_fifo_alarm) == 8'h00)
      else $error("lane alarm dropped");
   a_lane_set_enabled: assert property (!link_enable |=> (lane_fifo_alarm & ~$past(lane_fifo_alarm)) == 8'h00)
      else $error("lane alarm while disabled");
   a_no_ilas_64b: assert property (link_enable && $past(link_enable) && link_mode_select inside {5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'he} |-> !ilas_active)
      else $error("alignment sent in 64b66b");
   a_no_ilas_off: assert property (!link_enable [*2] |-> !ilas_active)
      else $error("alignment while disabled");
   a_params_frozen: assert property (s_en_rise ##1 s_en_held |-> $stable(ilas_checksum) && $stable(ilas_r_x8))
      else $error("parameters moved while enabled");
endmodule : jlink_monitor
`default_nettype wire

// >>> bench/jlink_bench.sv
// Self-checking bench joining both link ends
`timescale 1ns/1ps
`default_nettype none
`include "jlink_defines.svh"
module jlink_bench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic alarm_summary;
   logic [1:0] chan_a_clk_phase = 2'h1;
   logic [1:0] chan_b_clk_phase = 2'h1;
   logic [7:0] fifo_pointer_upset = 8'h00;
   logic [7:0] fifo_reset_n;
   logic [39:0] lane_id;
   logic [31:0] rd;
   int num_errors = 0;
   int n_tests = 0;
   jlink_if jlink_if_i ();
   jlink_device jlink_device_i (.sys_clk(sys_clk), .resetn(resetn), .link(jlink_if_i),
      .chan_a_clk_phase(chan_a_clk_phase), .chan_b_clk_phase(chan_b_clk_phase),
      .fifo_pointer_upset(fifo_pointer_upset), .fifo_reset_n(fifo_reset_n), .lane_id(lane_id));
   jlink_host jlink_host_i (.sys_clk(sys_clk), .resetn(resetn), .link(jlink_if_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .alarm_summary(alarm_summary));
   jlink_monitor jlink_monitor_i (.sys_clk(sys_clk), .resetn(resetn), .link_enable(jlink_if_i.link_enable),
      .power_down_channel_a(jlink_if_i.power_down_channel_a), .power_down_channel_b(jlink_if_i.power_down_channel_b),
      .link_mode_select(jlink_if_i.link_mode_select), .status_sel_alarm(jlink_if_i.status_sel_alarm),
      .clear_clock_alarm(jlink_if_i.clear_clock_alarm), .clear_lane_alarm(jlink_if_i.clear_lane_alarm),
      .clock_upset_alarm(jlink_if_i.clock_upset_alarm), .lane_fifo_alarm(jlink_if_i.lane_fifo_alarm),
      .calibration_status_pin(jlink_if_i.calibration_status_pin),
      .serializer_power_down(jlink_if_i.serializer_power_down), .ilas_checksum(jlink_if_i.ilas_checksum),
      .ilas_r_x8(jlink_if_i.ilas_r_x8), .ilas_active(jlink_if_i.ilas_active));
   always #25 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle
   // Read data is taken at the edge that ends the wait
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk iff avs_waitrequest === 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge sys_clk);
   endtask : bus
   task automatic glitch;
      @(posedge sys_clk);
      chan_b_clk_phase <= 2'h2;
      @(posedge sys_clk);
      chan_b_clk_phase <= 2'h1;
      idle(4);
   endtask : glitch
   task automatic upset(input logic [7:0] m);
      @(posedge sys_clk);
      fifo_pointer_upset <= m;
      repeat (4) @(posedge sys_clk);
      fifo_pointer_upset <= 8'h00;
      idle(4);
   endtask : upset
   task automatic t_reset;
      idle(1);
      chk(jlink_if_i.serializer_power_down, 1);
      bus(0, `REG_MASK, 0);
      chk(rd, {23'h0, `MASK_RESET});
      bus(0, 4'hf, 0);
      chk(rd, `UNMAPPED_READ);
      for (int g = 0; g < 8; g++) chk(lane_id[g*5 +: 5], g);
      $display("reset test done");
   endtask : t_reset
   // Last entry is an undefined mode: no alignment expected
   task automatic t_modes;
      int md[7] = '{0, 2, 3, 9, 5, 7, 12};
      int r8[7] = '{64, 80, 100, 40, 132, 66, 0};
      int sm[7] = '{47, 20, 31, 25, 0, 0, 0};
      int pf[7] = '{8, 1, 5, 1, 2, 1, 0};
      int pl[7] = '{8, 4, 4, 8, 2, 4, 0};
      int pm[7] = '{8, 4, 4, 4, 4, 4, 0};
      logic seen;
      for (int i = 0; i < 7; i++) begin
         bus(1, `REG_CTRL, 32'h0);
         bus(1, `REG_MODE, {8'h0, 8'ha5, 8'h1f, 3'h0, md[i][4:0]});
         bus(1, `REG_CTRL, {28'h0, i[0], 3'h1});
         seen = 1'b0;
         for (int c = 0; c < 20; c++) begin
            @(negedge sys_clk);
            seen |= jlink_if_i.ilas_active === 1'b1;
         end
         chk(seen, i < 4);
         if (i < 6) chk(jlink_if_i.ilas_r_x8, r8[i]);
         if (i < 4) chk(jlink_if_i.ilas_checksum, (sm[i] + 8'h1f + 8'ha5 + i % 2 + 2) & 255);
         bus(0, `REG_PARAM1, 0);
         chk(rd, {14'h0, pm[i][4:0], pl[i][4:0], pf[i][7:0]});
      end
      bus(1, `REG_MODE, 32'h0);
      bus(0, `REG_MODE, 0);
      chk(rd[4:0], 12);
      $display("mode test done");
   endtask : t_modes
   task automatic t_clock;
      bus(1, `REG_CTRL, 32'h0);
      bus(1, `REG_CTRL, 32'h11);
      bus(1, `REG_ALARM, 32'h100);
      idle(2);
      chk(jlink_if_i.clock_upset_alarm, 0);
      glitch();
      idle(8);
      chk(jlink_if_i.calibration_status_pin, 1);
      bus(0, `REG_ALARM, 0);
      chk(rd[8], 1);
      bus(1, `REG_ALARM, 32'h100);
      idle(2);
      chk(jlink_if_i.clock_upset_alarm, 0);
      bus(1, `REG_CTRL, 32'h13);
      glitch();
      chk(jlink_if_i.clock_upset_alarm, 0);
      $display("clock alarm test done");
   endtask : t_clock
   task automatic t_fifo;
      bus(1, `REG_CTRL, 32'h1);
      idle(2);
      chk(fifo_reset_n, 8'hff);
      upset(8'h08);
      bus(0, `REG_ALARM, 0);
      chk(rd, 32'h8);
      chk(alarm_summary, 0);
      bus(1, `REG_MASK, 32'h1f7);
      idle(2);
      chk(alarm_summary, 1);
      bus(1, `REG_CTRL, 32'h0);
      idle(2);
      chk(fifo_reset_n, 8'h00);
      chk(jlink_if_i.serializer_power_down, 1);
      upset(8'h10);
      bus(1, `REG_ALARM, 32'h8);
      bus(0, `REG_ALARM, 0);
      chk(rd, 0);
      chk(alarm_summary, 0);
      bus(1, `REG_CTRL, 32'h1);
      idle(2);
      chk(fifo_reset_n, 8'hff);
      $display("fifo alarm test done");
   endtask : t_fifo
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   // Whole run is well under a thousand cycles
   initial begin
      #400000;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_modes();
      t_clock();
      t_fifo();
      final_report();
   end
endmodule : jlink_bench
`default_nettype wire
